// ==== ovbe_pkg.sv ====
// Shared constants and carrier types for the output validity bi-phase encoder.
package ovbe_pkg;

  // ----------------------------------------------------------------------
  // Stream geometry
  // ----------------------------------------------------------------------

  // Number of reconstructed bit streams carried on one data connector.
  localparam int OVBE_STREAMS = 32;

  // Base aggregate rate of one channel quantum, in Mbit/s.
  localparam int OVBE_QUANTUM_MBPS = 1024;

  // Bit-stream clock in MHz that one full quantum implies at the base rate.
  localparam int OVBE_BASE_CLOCK_MHZ = OVBE_QUANTUM_MBPS / OVBE_STREAMS;

  // Bit-stream clock rates at which doubled line rate is considered risky.
  localparam int OVBE_RISKY_CLOCK_LO_MHZ = 64;
  localparam int OVBE_RISKY_CLOCK_HI_MHZ = 128;

  // ----------------------------------------------------------------------
  // Synchroniser depth
  // ----------------------------------------------------------------------

  // Two flip-flops per pin, plus one history stage for edge detection.
  localparam int OVBE_SYNC_STAGES = 3;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------

  // One bit cell for all streams, as handed in by the reconstruction path.
  typedef struct packed {
    logic [OVBE_STREAMS-1:0] data;  // Data value of each stream.
    logic [OVBE_STREAMS-1:0] valid; // Local validity of each stream bit.
    logic replaced;                 // Cell holds timing or sync filler.
  } ovbe_cell_t;

  // Static configuration straps driven by the surrounding logic.
  typedef struct packed {
    logic per_bit_mode;   // Bi-phase validity coding enabled.
    logic use_acq_valid;  // Acquisition valid gates the global valid.
  } ovbe_cfg_t;

  // Phase within the current bit cell.
  typedef enum logic [1:0] {
    OVBE_PH_IDLE,
    OVBE_PH_FIRST,
    OVBE_PH_SECOND
  } ovbe_phase_t;

endpackage

// ==== ovbe_encoder.sv ====
// Bi-phase validity encoder that drives the reconstructed bit streams and clock.
`timescale 1ns/1ns

// Summary of operation
// - Global valid shows all streams carry valid data.
// - Replaced timing cells drop global valid exactly.
// - Acquisition valid may gate the global valid.
// - Per-bit mode: data first half, validity second.
// - Invalid bit toggles at mid-cell; valid holds.
// - Coding off: level held for whole cell.
// - Per-bit validity is generated locally, never forwarded.
// - Parallel validity outputs mirror streams with clock.
// - Flag bi-phase use at 64 or 128 MHz.
// - One connector forms a 1.024 Gbps quantum.
// - Second-tick bit always sent with fixed timing.
module ovbe_encoder #(
  parameter int BIT_CLOCK_MHZ = ovbe_pkg::OVBE_BASE_CLOCK_MHZ
) (
  // System clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Pins from outside the clock domain.
  input wire logic link_clock_pin,
  input wire logic acquisition_data_valid,
  input wire logic one_second_tick,
  // Cell hand-in from the reconstruction path.
  input wire ovbe_pkg::ovbe_cell_t cell_in,
  input wire logic cell_in_valid,
  output logic cell_in_ready,
  // Configuration.
  input wire ovbe_pkg::ovbe_cfg_t cfg,
  // Data connector outputs.
  output logic [ovbe_pkg::OVBE_STREAMS-1:0] reconstructed_bit_stream,
  output logic reconstructed_clock,
  output logic global_output_valid,
  output logic second_tick_bit,
  // Parallel validity connector outputs.
  output logic [ovbe_pkg::OVBE_STREAMS-1:0] validity_stream,
  output logic validity_clock,
  // Status.
  output logic biphase_rate_warning
);
  import ovbe_pkg::*;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------

  // Shift chains for the link clock, acquisition valid and second tick.
  logic [OVBE_SYNC_STAGES-1:0] clk_chain;
  logic [OVBE_SYNC_STAGES-1:0] acq_chain;
  logic [OVBE_SYNC_STAGES-1:0] tick_chain;
  logic [OVBE_SYNC_STAGES-1:0] next_clk_chain;
  logic [OVBE_SYNC_STAGES-1:0] next_acq_chain;
  logic [OVBE_SYNC_STAGES-1:0] next_tick_chain;

  // Shift each pin in at the bottom; stage 0 is read only by stage 1.
  always_comb begin
    next_clk_chain = {clk_chain[OVBE_SYNC_STAGES-2:0], link_clock_pin};
    next_acq_chain = {acq_chain[OVBE_SYNC_STAGES-2:0], acquisition_data_valid};
    next_tick_chain = {tick_chain[OVBE_SYNC_STAGES-2:0], one_second_tick};
  end

  // Register the chains.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_chain <= '0;
      acq_chain <= '0;
      tick_chain <= '0;
    end else begin
      clk_chain <= next_clk_chain;
      acq_chain <= next_acq_chain;
      tick_chain <= next_tick_chain;
    end
  end

  // Synchronised levels and edges, all taken from stage 1 onward.
  logic rise_edge;
  logic fall_edge;
  logic acq_sync;
  logic tick_edge;

  // Edge detection compares the second stage against the history stage.
  always_comb begin
    rise_edge = clk_chain[1] & ~clk_chain[2];
    fall_edge = ~clk_chain[1] & clk_chain[2];
    acq_sync = acq_chain[1];
    tick_edge = tick_chain[1] & ~tick_chain[2];
  end

  // ----------------------------------------------------------------------
  // Second tick capture
  // ----------------------------------------------------------------------

  // Pending tick waits for the next cell start.
  logic tick_pending;
  logic next_tick_pending;

  // A new tick wins over the clear done at a cell start.
  always_comb begin
    next_tick_pending = tick_pending;
    if (rise_edge) begin
      next_tick_pending = 1'b0;
    end
    if (tick_edge) begin
      next_tick_pending = 1'b1;
    end
  end

  // Register the pending tick.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_pending <= 1'b0;
    end else begin
      tick_pending <= next_tick_pending;
    end
  end

  // ----------------------------------------------------------------------
  // Cell encoder
  // ----------------------------------------------------------------------

  // A cell is accepted only at the rising edge of the link clock.
  always_comb begin
    cell_in_ready = rise_edge;
  end

  // Current phase, latched validity mask and output registers.
  ovbe_phase_t phase;
  ovbe_phase_t next_phase;
  logic [OVBE_STREAMS-1:0] cell_valid;
  logic [OVBE_STREAMS-1:0] next_cell_valid;
  logic [OVBE_STREAMS-1:0] next_stream;
  logic next_rclk;
  logic next_gov;
  logic next_tick_bit;

  // Mid-cell toggle pattern: one for each invalid bit.
  logic [OVBE_STREAMS-1:0] toggle_mask;

  // Compute next outputs on each detected link clock edge.
  always_comb begin
    next_phase = phase;
    next_cell_valid = cell_valid;
    next_stream = reconstructed_bit_stream;
    next_rclk = reconstructed_clock;
    next_gov = global_output_valid;
    next_tick_bit = second_tick_bit;
    toggle_mask = ~cell_valid;
    unique case (phase)
      OVBE_PH_IDLE, OVBE_PH_FIRST, OVBE_PH_SECOND: begin
        if (rise_edge) begin
          // Start of a cell: data half goes out with the clock high.
          next_phase = OVBE_PH_FIRST;
          next_rclk = 1'b1;
          next_tick_bit = tick_pending;
          if (cell_in_valid) begin
            // Data value in the first half of the cell.
            next_stream = cell_in.data;
            // Local per-bit validity; replaced cells are wholly invalid.
            next_cell_valid = cell_in.valid & {OVBE_STREAMS{~cell_in.replaced}};
            // All streams valid, no filler, acquisition valid if used.
            next_gov = (&cell_in.valid) & ~cell_in.replaced
                       & (acq_sync | ~cfg.use_acq_valid);
          end else begin
            // Underrun: a defined, wholly invalid cell.
            next_stream = '0;
            next_cell_valid = '0;
            next_gov = 1'b0;
          end
        end else if (fall_edge && phase != OVBE_PH_IDLE) begin
          // Second half: clock low, validity half-cell.
          next_phase = OVBE_PH_SECOND;
          next_rclk = 1'b0;
          if (cfg.per_bit_mode) begin
            // Invalid bits change level, valid bits hold.
            next_stream = reconstructed_bit_stream ^ toggle_mask;
          end else begin
            // Coding off: level held through the cell.
            next_stream = reconstructed_bit_stream;
          end
        end
      end
    endcase
  end

  // Register the encoder state and outputs.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase <= OVBE_PH_IDLE;
      cell_valid <= '0;
      reconstructed_bit_stream <= '0;
      reconstructed_clock <= 1'b0;
      global_output_valid <= 1'b0;
      second_tick_bit <= 1'b0;
    end else begin
      phase <= next_phase;
      cell_valid <= next_cell_valid;
      reconstructed_bit_stream <= next_stream;
      reconstructed_clock <= next_rclk;
      global_output_valid <= next_gov;
      second_tick_bit <= next_tick_bit;
    end
  end

  // ----------------------------------------------------------------------
  // Parallel validity connector
  // ----------------------------------------------------------------------

  // The validity connector mirrors the data pin-out with its own clock copy.
  always_comb begin
    validity_stream = cell_valid;
    validity_clock = reconstructed_clock;
  end

  // ----------------------------------------------------------------------
  // Rate checks
  // ----------------------------------------------------------------------

  // Aggregate rate of this connector, in Mbit/s.
  localparam int QuantumMbps = OVBE_STREAMS * BIT_CLOCK_MHZ;

  // Bit clock counts as risky for bi-phase at or above the lower rate.
  localparam logic RiskyClock = (BIT_CLOCK_MHZ >= OVBE_RISKY_CLOCK_LO_MHZ);

  // Warn while bi-phase coding runs at a risky bit clock rate.
  always_comb begin
    biphase_rate_warning = cfg.per_bit_mode & RiskyClock;
  end

  // ----------------------------------------------------------------------
  // Filler tracking for checks
  // ----------------------------------------------------------------------

  // High while the cell on the pins was taken as replaced filler.
  logic filler_cell;
  logic next_filler_cell;

  // Each link rise decides afresh whether the new cell is filler.
  always_comb begin
    next_filler_cell = filler_cell;
    if (rise_edge) begin
      next_filler_cell = cell_in_valid & cell_in.replaced;
    end
  end

  // Register the filler marker in step with the output registers.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      filler_cell <= 1'b0;
    end else begin
      filler_cell <= next_filler_cell;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  // All valid, no filler and acquisition valid raise the global valid.
  a_gov_all_valid: assert property (@(posedge clk_sys) disable iff (rst)
    rise_edge && cell_in_valid && (&cell_in.valid) && !cell_in.replaced
      && (acq_sync || !cfg.use_acq_valid) |=> global_output_valid)
    else $error("Global valid low for a fully valid cell.");

  // A replaced cell keeps global valid low until the next cell starts.
  a_gov_replaced: assert property (@(posedge clk_sys) disable iff (rst)
    filler_cell |-> !global_output_valid)
    else $error("Global valid high during a replaced cell.");

  // Missing acquisition valid drops the global valid when used.
  a_gov_acq_gate: assert property (@(posedge clk_sys) disable iff (rst)
    rise_edge && cfg.use_acq_valid && !acq_sync |=> !global_output_valid)
    else $error("Global valid ignores acquisition valid.");

  // First half of a cell carries the data value.
  a_first_half_data: assert property (@(posedge clk_sys) disable iff (rst)
    rise_edge && cell_in_valid |=> reconstructed_bit_stream == $past(cell_in.data))
    else $error("First half does not carry the cell data.");

  // Mid-cell toggle flips exactly the invalid bits.
  a_mid_toggle: assert property (@(posedge clk_sys) disable iff (rst)
    fall_edge && phase == OVBE_PH_FIRST && cfg.per_bit_mode
      |=> reconstructed_bit_stream == ($past(reconstructed_bit_stream) ^ ~validity_stream))
    else $error("Mid-cell transition does not match validity.");

  // With coding off the level holds across the falling edge.
  a_level_hold: assert property (@(posedge clk_sys) disable iff (rst)
    fall_edge && !cfg.per_bit_mode |=> $stable(reconstructed_bit_stream))
    else $error("Stream changed mid-cell with coding off.");

  // Per-bit validity follows the local mask, not acquisition valid.
  a_local_validity: assert property (@(posedge clk_sys) disable iff (rst)
    rise_edge && cell_in_valid
      |=> validity_stream == $past(cell_in.valid & {OVBE_STREAMS{~cell_in.replaced}}))
    else $error("Validity outputs do not mirror local validity.");

  // Output clock follows the link edges one cycle later.
  a_clock_follow: assert property (@(posedge clk_sys) disable iff (rst)
    (rise_edge |=> reconstructed_clock && validity_clock)
      and (fall_edge && phase != OVBE_PH_IDLE |=> !reconstructed_clock))
    else $error("Reconstructed clock not aligned to link edges.");

  // A pending tick marks the next cell and is then cleared.
  a_tick_cell: assert property (@(posedge clk_sys) disable iff (rst)
    rise_edge && tick_pending && !tick_edge |=> second_tick_bit && !tick_pending)
    else $error("Second tick bit not sent in the next cell.");

  // The rate warning follows mode and clock rate.
  a_rate_warn: assert property (@(posedge clk_sys) disable iff (rst)
    biphase_rate_warning == (cfg.per_bit_mode && BIT_CLOCK_MHZ >= OVBE_RISKY_CLOCK_LO_MHZ))
    else $error("Bi-phase rate warning does not follow mode and clock.");

  // The configured stream count and clock make up a full quantum unless the clock is below the base rate.
  a_quantum_rate: assert property (@(posedge clk_sys) disable iff (rst)
    QuantumMbps >= OVBE_QUANTUM_MBPS || BIT_CLOCK_MHZ < OVBE_BASE_CLOCK_MHZ)
    else $error("Connector does not form a full channel quantum.");

endmodule

// ==== ovbe_rx_model.sv ====
// Behavioural model of the downstream processing system watching the streams.
`timescale 1ns/1ns

module ovbe_rx_model (
  // System clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Data connector seen from the receiver.
  input wire logic reconstructed_clock,
  input wire logic [31:0] reconstructed_bit_stream,
  // Captured halves of the most recent cell, and a count of clock falls.
  output logic [31:0] first_half,
  output logic [31:0] second_half,
  output logic [15:0] fall_cnt
);
  logic prev_clk; // Clock level seen at the previous sample.

  // Samples away from the launching edge so both halves are settled.
  always @(negedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_clk <= 1'b0;
      first_half <= 32'h0;
      second_half <= 32'h0;
      fall_cnt <= 16'h0;
    end else begin
      prev_clk <= reconstructed_clock;
      if (reconstructed_clock && !prev_clk) begin
        first_half <= reconstructed_bit_stream;
      end
      if (!reconstructed_clock && prev_clk) begin
        second_half <= reconstructed_bit_stream;
        fall_cnt <= fall_cnt + 16'h1;
      end
    end
  end
endmodule

// ==== output_validity_biphase_encoder_tb.sv ====
// Self-checking testbench for the bi-phase validity encoder.
`timescale 1ns/1ns

module output_validity_biphase_encoder_tb;
  import ovbe_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk_sys, rst, link_clock_pin, acquisition_data_valid, one_second_tick;
  ovbe_cell_t cell_in;
  logic cell_in_valid, cell_in_ready, reconstructed_clock, global_output_valid;
  ovbe_cfg_t cfg;
  logic [31:0] reconstructed_bit_stream, validity_stream, first_half, second_half;
  logic second_tick_bit, validity_clock, biphase_rate_warning;
  logic [15:0] fall_cnt;
  int error_cnt, compares;
  logic [31:0] rnd; // Random source state.

  // A 64 MHz setting makes the warning follow the coding mode.
  ovbe_encoder #(.BIT_CLOCK_MHZ(64)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .link_clock_pin(link_clock_pin), .acquisition_data_valid(acquisition_data_valid),
    .one_second_tick(one_second_tick), .cell_in(cell_in), .cell_in_valid(cell_in_valid),
    .cell_in_ready(cell_in_ready), .cfg(cfg),
    .reconstructed_bit_stream(reconstructed_bit_stream),
    .reconstructed_clock(reconstructed_clock), .global_output_valid(global_output_valid),
    .second_tick_bit(second_tick_bit), .validity_stream(validity_stream),
    .validity_clock(validity_clock), .biphase_rate_warning(biphase_rate_warning));

  ovbe_rx_model u_rx (.clk_sys(clk_sys), .rst(rst), .reconstructed_clock(reconstructed_clock),
    .reconstructed_bit_stream(reconstructed_bit_stream), .first_half(first_half),
    .second_half(second_half), .fall_cnt(fall_cnt));

  // ----------------------------------------------------------------------
  // Clocks and helpers
  // ----------------------------------------------------------------------
  // System clock at 10 ns, link clock at 80 ns with an unrelated phase.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    link_clock_pin = 1'b0;
    #3;
    forever #40 link_clock_pin = ~link_clock_pin;
  end

  // Next value of the random source.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Compares one value and counts it.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits for the edge at which the encoder takes a cell; ready is looked at mid-cycle.
  task take();
    int n;
    n = 0;
    while (cell_in_ready !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk({31'h0, n < 40}, 32'h1);
    @(posedge clk_sys);
  endtask

  // Offers one cell for two link periods and checks the second one sent.
  task run_cell(input logic [31:0] d, input logic [31:0] v, input logic rp,
                input logic cv, input logic [1:0] md, input logic aq, input logic tk);
    logic [31:0] ed, ev;
    logic eg;
    int n;
    logic [15:0] fc;
    @(negedge clk_sys);
    cell_in <= {d, v, rp};
    cell_in_valid <= cv;
    cfg <= md;
    acquisition_data_valid <= aq;
    one_second_tick <= 1'b0;
    take();
    @(negedge clk_sys);
    one_second_tick <= tk;
    take();
    ed = cv ? d : 32'h0;
    ev = (cv && !rp) ? v : 32'h0;
    eg = cv & ~rp & (&v) & (aq | ~md[0]);
    fc = fall_cnt;
    @(negedge clk_sys);
    chk(reconstructed_bit_stream, ed);
    chk({31'h0, reconstructed_clock}, 32'h1);
    chk({31'h0, cell_in_ready}, 32'h0);
    chk({31'h0, global_output_valid}, {31'h0, eg});
    chk({31'h0, second_tick_bit}, {31'h0, tk});
    chk(validity_stream, ev);
    chk({31'h0, validity_clock}, {31'h0, reconstructed_clock});
    chk({31'h0, biphase_rate_warning}, {31'h0, md[1]});
    n = 0;
    while (fall_cnt === fc && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk({31'h0, fall_cnt !== fc}, 32'h1);
    chk(first_half, ed);
    chk(second_half, md[1] ? (ed ^ ~ev) : ed);
    chk(~(first_half ^ second_half), md[1] ? ev : 32'hffffffff);
    $display("cell test done at %0t", $time);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task results();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    acquisition_data_valid = 1'b0;
    one_second_tick = 1'b0;
    cell_in = '0;
    cell_in_valid = 1'b0;
    cfg = '0;
    error_cnt = 0;
    compares = 0;
    rnd = 32'd96781;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    // Every coding and gating mode, with acquisition valid low and high.
    for (int m = 0; m < 4; m++) begin
      rnd = lfsr(rnd);
      run_cell(rnd, 32'hffffffff, 1'b0, 1'b1, m[1:0], 1'b0, 1'b1);
      run_cell(~rnd, 32'hffffffff, 1'b0, 1'b1, m[1:0], 1'b1, 1'b0);
    end
    // Replaced filler cell, then an underrun with no cell offered.
    run_cell(32'h5a5a0ff0, 32'hffffffff, 1'b1, 1'b1, 2'b10, 1'b1, 1'b0);
    run_cell(32'hffffffff, 32'hffffffff, 1'b0, 1'b0, 2'b10, 1'b1, 1'b1);
    // Random cells.
    for (int i = 0; i < 30; i++) begin
      rnd = lfsr(rnd);
      run_cell(rnd, lfsr(rnd) | {32{rnd[3]}}, rnd[5] & rnd[9], 1'b1, rnd[1:0], rnd[7],
               rnd[11]);
    end
    results();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    results();
  end
endmodule
